// [design/p4g_defs.svh]
// constants for the port-4 general-purpose port block
// assumes byte-wide registers on a 32-bit avalon-mm word bus
`ifndef P4G_DEFS_SVH
`define P4G_DEFS_SVH

// ****************************************
// register byte addresses
// ****************************************
`define P4G_ADDR_LATCH 8'hC0
`define P4G_ADDR_DIR 8'hC4
`define P4G_ADDR_PULLDIS 8'hC8
`define P4G_ADDR_ODSEL 8'hCC
`define P4G_ADDR_PCTRL 8'hD0
`define P4G_ADDR_PSAVE 8'hD4
`define P4G_ADDR_XCVR 8'hD8
`define P4G_ADDR_MODE 8'hDC
`define P4G_ADDR_STATUS 8'hE0

// ****************************************
// field positions and reset values
// ****************************************
`define P4G_PCTRL_RDSRC 5
`define P4G_PSAVE_HIZ 0
`define P4G_XCVR_RADIO_POWER_OUTPUT 0
`define P4G_XCVR_SYNTHESIZER_SWITCH_OUTPUT 1
`define P4G_XCVR_LOCK 2
`define P4G_MODE_EXTMEM 0
`define P4G_RST_BYTE 8'h00
`define P4G_UNMAPPED 32'h0000_0000

`endif

// [design/p4g_pin_sync.sv]
// two-flop synchroniser for the eight pad inputs
// assumes pads are asynchronous to clk
`timescale 1ns/1ps
module p4g_pin_sync (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] pin_async,
  output logic [7:0] pin_sync
);
  logic [7:0] meta_r;

  // first stage read only by the second
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_r <= 8'h00;
      pin_sync <= 8'h00;
    end else begin
      meta_r <= pin_async;
      pin_sync <= meta_r;
    end
  end
endmodule : p4g_pin_sync

// [design/p4g_pkg.sv]
// types shared by the port-4 block
// assumes p4g_defs.svh is on the include path
package p4g_pkg;

  typedef enum logic [2:0] {
    P4G_IDLE = 3'b001,
    P4G_ACK = 3'b010,
    P4G_DONE = 3'b100
  } p4g_bus_state_type;

  typedef struct packed {
    logic [7:0] out_val;
    logic [7:0] out_en_n;
    logic [7:0] pullup_en;
  } p4g_pad_type;

  typedef struct packed {
    logic ale;
    logic psen;
    logic rf_pwr;
    logic pll_sw;
    logic lock;
  } p4g_special_type;

endpackage : p4g_pkg

// [design/p4g_port.sv]
// port-4 general-purpose port with avalon-mm register slave
// assumes pads resolve out_val/out_en_n/pullup_en externally; clk 10 MHz
//
// Functional notes
// - in external memory mode bits 2 and 3 carry the address latch and program store strobes.
// - with external memory mode off all eight pins are bidirectional general-purpose lines.
// - in that mode pins 0, 1 and 2 may carry radio power, synthesizer switch and lock outputs.
// - a port read returns pin levels when read-source is 0 and the latch when it is 1.
// - each bit has its own direction bit, 1 output and 0 input.
// - reset clears all direction bits so every pin starts as input.
// - an input pin has its pull-up removed when its pull-up disable bit is 1.
// - reset clears all pull-up disable bits so pull-ups are connected.
// - power-save high impedance removes pull-ups of input pins and floats them.
// - an output pin's pull-up follows only its pull-up disable bit.
// - power-save high impedance also floats output pins over the latch.
// - special radio outputs appear only when enabled in the transceiver control bits.
// - each pin's open-drain select bit picks push-pull at 0 and open-drain at 1.
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "p4g_defs.svh"
module p4g_port
  import p4g_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [7:0] pad_in,
  input wire p4g_special_type special_in,
  output p4g_pad_type pad_out
);

  // ****************************************
  // state
  // ****************************************
  p4g_bus_state_type state_r;
  p4g_bus_state_type state_nxt;
  logic [7:0] latch_r;
  logic [7:0] dir_r;
  logic [7:0] pulldis_r;
  logic [7:0] odsel_r;
  logic [7:0] pctrl_r;
  logic [7:0] psave_r;
  logic [7:0] xcvr_r;
  logic [7:0] mode_r;
  logic [7:0] pin_s;
  logic [31:0] rd_nxt;
  logic wr_go;
  logic rd_go;
  logic wr_latch;
  logic wr_dir;
  logic wr_pulldis;
  logic wr_odsel;
  logic wr_pctrl;
  logic wr_psave;
  logic wr_xcvr;
  logic wr_mode;
  logic [7:0] en_n_nxt;
  logic [7:0] pu_nxt;
  logic power_save_high_impedance;
  logic extmem;
  logic [7:0] spec_en;
  logic [7:0] spec_val;
  logic [7:0] drv_val;
  p4g_pad_type pad_nxt;

  p4g_pin_sync u_sync (
    .clk(clk),
    .reset(reset),
    .pin_async(pad_in),
    .pin_sync(pin_s)
  );

  // ****************************************
  // avalon slave: one wait cycle, answer on second edge
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      P4G_IDLE: begin
        if (avs_read || avs_write) begin
          state_nxt = P4G_ACK;
        end
      end
      P4G_ACK: begin
        state_nxt = P4G_DONE;
      end
      P4G_DONE: begin
        state_nxt = P4G_IDLE;
      end
      default: begin
        state_nxt = P4G_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= P4G_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // waitrequest low only in the ack cycle, so each access is taken once
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(state_nxt == P4G_ACK);
    end
  end

  assign wr_go = (state_r == P4G_ACK) && avs_write && avs_byteenable[0];
  // read data is loaded on the edge that opens the ack cycle
  assign rd_go = (state_nxt == P4G_ACK) && avs_read;

  // ****************************************
  // write strobes, one per register
  // ****************************************
  assign wr_latch = wr_go && (avs_address == `P4G_ADDR_LATCH);
  assign wr_dir = wr_go && (avs_address == `P4G_ADDR_DIR);
  assign wr_pulldis = wr_go && (avs_address == `P4G_ADDR_PULLDIS);
  assign wr_odsel = wr_go && (avs_address == `P4G_ADDR_ODSEL);
  assign wr_pctrl = wr_go && (avs_address == `P4G_ADDR_PCTRL);
  assign wr_psave = wr_go && (avs_address == `P4G_ADDR_PSAVE);
  assign wr_xcvr = wr_go && (avs_address == `P4G_ADDR_XCVR);
  assign wr_mode = wr_go && (avs_address == `P4G_ADDR_MODE);

  // ****************************************
  // register writes
  // ****************************************
  // latch write
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      latch_r <= `P4G_RST_BYTE;
    end else if (wr_latch) begin
      latch_r <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dir_r <= `P4G_RST_BYTE;
    end else if (wr_dir) begin
      dir_r <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pulldis_r <= `P4G_RST_BYTE;
    end else if (wr_pulldis) begin
      pulldis_r <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      odsel_r <= `P4G_RST_BYTE;
    end else if (wr_odsel) begin
      odsel_r <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pctrl_r <= `P4G_RST_BYTE;
    end else if (wr_pctrl) begin
      pctrl_r <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      psave_r <= `P4G_RST_BYTE;
    end else if (wr_psave) begin
      psave_r <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      xcvr_r <= `P4G_RST_BYTE;
    end else if (wr_xcvr) begin
      xcvr_r <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_r <= `P4G_RST_BYTE;
    end else if (wr_mode) begin
      mode_r <= avs_writedata[7:0];
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  always_comb begin
    rd_nxt = `P4G_UNMAPPED;
    if (avs_address == `P4G_ADDR_LATCH) begin
      rd_nxt[7:0] = pctrl_r[`P4G_PCTRL_RDSRC] ? latch_r : pin_s;
    end else if (avs_address == `P4G_ADDR_DIR) begin
      rd_nxt[7:0] = dir_r;
    end else if (avs_address == `P4G_ADDR_PULLDIS) begin
      rd_nxt[7:0] = pulldis_r;
    end else if (avs_address == `P4G_ADDR_ODSEL) begin
      rd_nxt[7:0] = odsel_r;
    end else if (avs_address == `P4G_ADDR_PCTRL) begin
      rd_nxt[7:0] = pctrl_r;
    end else if (avs_address == `P4G_ADDR_PSAVE) begin
      rd_nxt[7:0] = psave_r;
    end else if (avs_address == `P4G_ADDR_XCVR) begin
      rd_nxt[7:0] = xcvr_r;
    end else if (avs_address == `P4G_ADDR_MODE) begin
      rd_nxt[7:0] = mode_r;
    end else if (avs_address == `P4G_ADDR_STATUS) begin
      rd_nxt[7:0] = pad_out.out_en_n;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_go) begin
      avs_readdata <= rd_nxt;
    end
  end

  // ****************************************
  // special functions
  // ****************************************
  assign power_save_high_impedance = psave_r[`P4G_PSAVE_HIZ];
  assign extmem = mode_r[`P4G_MODE_EXTMEM];

  always_comb begin
    spec_en = 8'h00;
    spec_val = 8'h00;
    if (extmem) begin
      // strobes on bits 2 and 3
      spec_en[2] = 1'b1;
      spec_val[2] = special_in.ale;
      spec_en[3] = 1'b1;
      spec_val[3] = special_in.psen;
    end else begin
      spec_en[0] = xcvr_r[`P4G_XCVR_RADIO_POWER_OUTPUT];
      spec_val[0] = special_in.rf_pwr;
      spec_en[1] = xcvr_r[`P4G_XCVR_SYNTHESIZER_SWITCH_OUTPUT];
      spec_val[1] = special_in.pll_sw;
      spec_en[2] = xcvr_r[`P4G_XCVR_LOCK];
      spec_val[2] = special_in.lock;
    end
  end

  // ****************************************
  // per-pin driver
  // ****************************************
  // eight independent bidirectional lines
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
      logic want_drive;
      assign want_drive = dir_r[gi] || spec_en[gi];
      assign drv_val[gi] = spec_en[gi] ? spec_val[gi] : latch_r[gi];
      always_comb begin
        en_n_nxt[gi] = 1'b1;
        pu_nxt[gi] = !pulldis_r[gi];
        if (power_save_high_impedance) begin
          en_n_nxt[gi] = 1'b1;
        end else if (want_drive) begin
          en_n_nxt[gi] = odsel_r[gi] ? drv_val[gi] : 1'b0;
        end
        if (power_save_high_impedance && !want_drive) begin
          pu_nxt[gi] = 1'b0;
        end
      end
    end
  endgenerate

  // ****************************************
  // pad bundle
  // ****************************************
  // one driver for the whole bundle keeps the per-bit logic in plain vectors
  assign pad_nxt = {drv_val, en_n_nxt, pu_nxt};

  // registered pads: one clock of latency traded for clean outputs
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pad_out.out_val <= 8'h00;
      pad_out.out_en_n <= 8'hFF;
      pad_out.pullup_en <= 8'hFF;
    end else begin
      pad_out <= pad_nxt;
    end
  end

endmodule : p4g_port

// [dv/p4g_pad_model.sv]
// pin model: pads, outside driver and pull-ups
// assumes the testbench drives ext_drv and ext_en
`timescale 1ns/1ps
module p4g_pad_model
  import p4g_pkg::*;
(
  input wire logic clk,
  input wire p4g_pad_type pad_out,
  input wire logic [7:0] ext_drv,
  input wire logic [7:0] ext_en,
  output logic [7:0] pad_in
);
  // a floating pin toggles each cycle, so no settled level is trusted
  logic [7:0] last_r = 8'h00;
  logic [7:0] rel;
  assign rel = pad_out.out_en_n;
  assign pad_in = (~rel & pad_out.out_val) | (rel & ext_en & ext_drv) | (rel & ~ext_en & (pad_out.pullup_en | ~last_r));
  always_ff @(posedge clk) begin
    last_r <= pad_in;
  end
endmodule : p4g_pad_model

// [dv/p4g_port_assertions.sv]
// checker for p4g_port, bound from the testbench
// assumes p4g_defs.svh map; pads follow registers one edge late
`timescale 1ns/1ps
`include "p4g_defs.svh"
module p4g_port_assertions
  import p4g_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [7:0] pad_in,
  input wire p4g_special_type special_in,
  input wire p4g_pad_type pad_out
);
  // ****************************************
  // shadow registers and checks
  // ****************************************
  logic [7:0] lat_r, dir_r, pd_r, od_r, oen, val, pu;
  logic hiz_r, ext_r, rf_r;
  assign oen = pad_out.out_en_n;
  assign val = pad_out.out_val;
  assign pu = pad_out.pullup_en;
  // shadow only accepted writes, so a refused write cannot hide a fault
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      {lat_r, dir_r, pd_r, od_r, hiz_r, ext_r, rf_r} <= '0;
    end else if (avs_write && !avs_waitrequest && avs_byteenable[0]) begin
      case (avs_address)
        `P4G_ADDR_LATCH: lat_r <= avs_writedata[7:0];
        `P4G_ADDR_DIR: dir_r <= avs_writedata[7:0];
        `P4G_ADDR_PULLDIS: pd_r <= avs_writedata[7:0];
        `P4G_ADDR_ODSEL: od_r <= avs_writedata[7:0];
        `P4G_ADDR_PSAVE: hiz_r <= avs_writedata[0];
        `P4G_ADDR_XCVR: rf_r <= avs_writedata[0];
        `P4G_ADDR_MODE: ext_r <= avs_writedata[0];
        default: ;
      endcase
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  AST_WAIT_ONE: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("wait low too long");
  AST_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |-> ##[1:3] !avs_waitrequest)
    else $error("no bus answer");
  AST_RESET_OUT: assert property ($fell(reset) |-> oen == 8'hff && pu == 8'hff)
    else $error("pads not reset");
  AST_PULLUP: assert property ($past(!hiz_r) |-> pu == ~$past(pd_r))
    else $error("pull-up wrong");
  AST_HIZ: assert property ($past(hiz_r) |-> oen == 8'hff && (pu & ~$past(dir_r)) == 8'h00)
    else $error("hiz not floating");
  AST_DRIVE: assert property ($past(!hiz_r) |->
    oen[7:4] == ~($past(dir_r[7:4]) & ~($past(od_r[7:4]) & $past(lat_r[7:4]))))
    else $error("enable wrong");
  AST_VALUE: assert property (((val ^ $past(lat_r)) & ~oen & 8'hf0) == 8'h00)
    else $error("value not latch");
  AST_STROBES: assert property ($past(ext_r && !hiz_r && od_r[3:2] == 2'b00) |-> oen[3:2] == 2'b00
    && val[3:2] == {$past(special_in.psen), $past(special_in.ale)})
    else $error("strobes wrong");
  AST_RF_ON: assert property ($past(rf_r && !ext_r && !hiz_r && !od_r[0]) |->
    !oen[0] && val[0] == $past(special_in.rf_pwr))
    else $error("radio power wrong");
  AST_RF_OFF: assert property ($past(!rf_r && !hiz_r && !dir_r[0]) |-> oen[0])
    else $error("bit 0 driven");
  cover property (avs_write && !avs_waitrequest);
  cover property (hiz_r);
  cover property (ext_r);
endmodule : p4g_port_assertions

// [dv/test_p4g_port.sv]
// testbench for p4g_port: bus master tasks and pin scenarios
// assumes p4g_pad_model on the pads, checker bound at the foot
`timescale 1ns/1ps
`include "p4g_defs.svh"
module test_p4g_port
  import p4g_pkg::*;
;
  // ****************************************
  // stimulus and scenarios
  // ****************************************
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest;
  logic [7:0] pad_in;
  logic [7:0] ext_drv = 8'h00;
  logic [7:0] ext_en = 8'h00;
  p4g_special_type special_in = 5'h00;
  p4g_pad_type pad_out;
  int num_errors = 0;
  int checked = 0;
  p4g_port i_p4g_port (.clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pad_in(pad_in),
    .special_in(special_in), .pad_out(pad_out));
  p4g_pad_model i_p4g_pad_model (.clk(clk), .pad_out(pad_out), .ext_drv(ext_drv), .ext_en(ext_en),
    .pad_in(pad_in));
  initial forever #50 clk = ~clk;
  task automatic end_sim;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one access; waitrequest and read data are taken at the rising edge itself
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
    logic w = 1'b1;
    int n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h00_0000, d};
    while (w && n < 20) begin
      @(posedge clk);
      w = (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      n++;
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (w) begin
      num_errors++;
      end_sim();
    end
  endtask : acc
  task automatic settle;
    repeat (4) @(negedge clk);
  endtask : settle
  task automatic t_reset;
    chk(pad_out.out_en_n, 8'hff);
    chk(pad_out.pullup_en, 8'hff);
    acc(0, `P4G_ADDR_DIR, 8'h00);
    chk(rd[7:0], 8'h00);
    acc(0, `P4G_ADDR_PULLDIS, 8'h00);
    chk(rd[7:0], 8'h00);
    acc(1, 8'he8, 8'hff);
    acc(0, 8'he8, 8'h00);
    chk(rd[7:0], 8'h00);
  endtask : t_reset
  task automatic t_read_src;
    ext_en <= 8'hff;
    ext_drv <= 8'ha5;
    acc(1, `P4G_ADDR_LATCH, 8'h3c);
    acc(0, `P4G_ADDR_LATCH, 8'h00);
    chk(rd[7:0], 8'ha5);
    acc(1, `P4G_ADDR_PCTRL, 8'h20);
    avs_byteenable <= 4'he;
    acc(1, `P4G_ADDR_LATCH, 8'hff);
    avs_byteenable <= 4'hf;
    acc(0, `P4G_ADDR_LATCH, 8'h00);
    chk(rd[7:0], 8'h3c);
    acc(1, `P4G_ADDR_PCTRL, 8'h00);
    ext_en <= 8'h00;
  endtask : t_read_src
  task automatic t_output;
    acc(1, `P4G_ADDR_DIR, 8'h0f);
    acc(1, `P4G_ADDR_LATCH, 8'h05);
    settle();
    chk(pad_out.out_en_n, 8'hf0);
    chk(pad_out.out_val & 8'h0f, 8'h05);
    acc(1, `P4G_ADDR_ODSEL, 8'hff);
    settle();
    chk(pad_out.out_en_n, 8'hf5);
    acc(0, `P4G_ADDR_LATCH, 8'h00);
    chk(rd[7:0], 8'hf5);
    acc(0, `P4G_ADDR_STATUS, 8'h00);
    chk(rd[7:0], 8'hf5);
    acc(1, `P4G_ADDR_ODSEL, 8'h00);
  endtask : t_output
  task automatic t_pullup;
    acc(1, `P4G_ADDR_PULLDIS, 8'h3c);
    settle();
    chk(pad_out.pullup_en, 8'hc3);
    acc(1, `P4G_ADDR_PSAVE, 8'h01);
    settle();
    chk(pad_out.out_en_n, 8'hff);
    chk(pad_out.pullup_en & 8'hf0, 8'h00);
    acc(1, `P4G_ADDR_PSAVE, 8'h00);
    acc(1, `P4G_ADDR_PULLDIS, 8'h00);
  endtask : t_pullup
  task automatic t_special;
    special_in <= 5'b01101;
    acc(1, `P4G_ADDR_DIR, 8'h00);
    settle();
    chk(pad_out.out_en_n, 8'hff);
    acc(1, `P4G_ADDR_XCVR, 8'h07);
    settle();
    chk(pad_out.out_en_n, 8'hf8);
    chk(pad_out.out_val & 8'h07, 8'h05);
    @(posedge clk);
    special_in <= 5'b10110;
    settle();
    chk(pad_out.out_val & 8'h07, 8'h03);
    acc(1, `P4G_ADDR_XCVR, 8'h00);
    acc(1, `P4G_ADDR_MODE, 8'h01);
    settle();
    chk(pad_out.out_en_n, 8'hf3);
    chk(pad_out.out_val & 8'h0c, 8'h04);
    acc(1, `P4G_ADDR_MODE, 8'h00);
    settle();
    chk(pad_out.out_en_n, 8'hff);
  endtask : t_special
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_read_src();
    t_output();
    t_pullup();
    t_special();
    end_sim();
  end
endmodule : test_p4g_port
bind p4g_port p4g_port_assertions i_p4g_port_assertions (.clk(clk), .reset(reset), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pad_in(pad_in),
  .special_in(special_in), .pad_out(pad_out));
